// >>> cdc_pkg.sv
// package for the clock divider and generator control block
// Overview of operation
// - bits 15 to 13 read as zero and ignore writes.
// - bit 12 puts both generator outputs into high-current drive.
// - each sinc unit runs only while bit 11 and its own enable are one.
// - the signal generator runs only while bit 10 holds one.
// - writing one to bit 9 while idle starts calibration on the selected module.
// - bit 9 reads one while calibration runs and zero otherwise.
// - the two-bit select field picks modules one to four for codes 0-3.
// - the generator clock divides by the four-bit field value plus one.
// - the modulator clock divides by the three-bit field value plus one.
package cdc_pkg;
  // ------------------------------------------------------------
  // register map and field positions
  // ------------------------------------------------------------
  localparam logic [11:0] CDC_CTRL_OFFSET = 12'h000;
  localparam logic [15:0] CDC_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] CDC_CTRL_WMASK  = 16'h1fff;
  localparam int          CDC_HIGH_DRIVE_BIT = 12;
  localparam int          CDC_GFE_BIT        = 11;
  localparam int          CDC_SGE_BIT        = 10;
  localparam int          CDC_PHASE_CAL_START_BUSY_BIT       = 9;
  localparam int          CDC_SEL_LSB        = 7;
  localparam int          CDC_MOD_LSB        = 4;
  localparam int          CDC_SG_LSB         = 0;
  localparam int          CDC_NUM_MODULES    = 4;

  typedef struct packed {
    logic       genHighDrive;
    logic       globalFilterEnable;
    logic       siggenEnable;
    logic [1:0] calChannelSelect;
    logic [2:0] modulatorClockDiv;
    logic [3:0] siggenClockDiv;
  } cdc_ctrl_t;

  typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} cdc_cal_state_t;
endpackage

// >>> cdc_clock_divider_control.sv
// clock divider and generator control register block with apb slave
`timescale 1ns/1ps
module cdc_clock_divider_control (
  input  wire logic                               sys_clk,
  input  wire logic                               reset_n,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [cdc_pkg::CDC_NUM_MODULES-1:0] perModuleSincEnable,
  input  wire logic                               calDone,
  output logic      [cdc_pkg::CDC_NUM_MODULES-1:0] sincRun,
  output logic                                    siggenRun,
  output logic                                    genHighDriveA,
  output logic                                    genHighDriveB,
  output logic                                    calStart,
  output logic      [cdc_pkg::CDC_NUM_MODULES-1:0] calModule,
  output logic                                    modClkTick,
  output logic                                    sgClkTick
);
  import cdc_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ------------------------------------------------------------
  // register and calibration state
  // ------------------------------------------------------------
  cdc_ctrl_t      ctrl;
  cdc_ctrl_t      next_ctrl;
  cdc_cal_state_t calState;
  cdc_cal_state_t next_calState;
  logic [31:0]    next_prdata;
  logic           next_pready;
  logic           next_pslverr;
  logic           next_calStart;
  logic [3:0]     next_calModule;
  logic           wrAcc;
  logic           hit;
  logic [15:0]    wval;
  logic [15:0]    rval;

  assign hit   = (paddr == CDC_CTRL_OFFSET);
  assign wrAcc = psel && penable && !pready && pwrite && hit;

  always_comb begin
    next_ctrl      = ctrl;
    next_calState  = calState;
    next_prdata    = 32'h0000_0000;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_calStart  = 1'b0;
    next_calModule = calModule;
    wval = 16'h0000;
    // bits 15..13 are never stored and read zero
    rval = {3'b000, ctrl.genHighDrive, ctrl.globalFilterEnable,
            ctrl.siggenEnable, calState == CAL_RUN,
            ctrl.calChannelSelect, ctrl.modulatorClockDiv,
            ctrl.siggenClockDiv};
    // one-wait slave: pready rises in the second access cycle
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !hit;
      if (!pwrite && hit) begin
        next_prdata = {16'h0000, rval};
      end
    end
    if (wrAcc) begin
      // lanes without a strobe keep what the register holds now
      wval = ({pwdata[15:8] & {8{pstrb[1]}}, pwdata[7:0] & {8{pstrb[0]}}}
              & CDC_CTRL_WMASK)
             | (rval & ~{{8{pstrb[1]}}, {8{pstrb[0]}}});
      if (pstrb[1]) begin
        next_ctrl.genHighDrive       = wval[CDC_HIGH_DRIVE_BIT];
        next_ctrl.globalFilterEnable = wval[CDC_GFE_BIT];
        next_ctrl.siggenEnable       = wval[CDC_SGE_BIT];
        next_ctrl.calChannelSelect[1] = wval[CDC_SEL_LSB+1];
      end
      if (pstrb[0]) begin
        next_ctrl.calChannelSelect[0] = wval[CDC_SEL_LSB];
        next_ctrl.modulatorClockDiv = wval[CDC_MOD_LSB +: 3];
        next_ctrl.siggenClockDiv    = wval[CDC_SG_LSB +: 4];
      end
    end
    unique case (calState)
      CAL_IDLE: begin
        if (wrAcc && pstrb[1] && wval[CDC_PHASE_CAL_START_BUSY_BIT]) begin
          next_calState  = CAL_RUN;
          next_calStart  = 1'b1;
          // one-hot of the select code in force after this write
          next_calModule = 4'b0001 << next_ctrl.calChannelSelect;
        end
      end
      CAL_RUN: begin
        // a start written while busy is ignored
        if (calDone) begin
          next_calState = CAL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      // bit 9 is live status, so it has no storage to reset
      ctrl      <= cdc_ctrl_t'({CDC_CTRL_RESET[12:10], CDC_CTRL_RESET[8:0]});
      calState  <= CAL_IDLE;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      calStart  <= 1'b0;
      calModule <= 4'h0;
    end else begin
      ctrl      <= next_ctrl;
      calState  <= next_calState;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      calStart  <= next_calStart;
      calModule <= next_calModule;
    end
  end

  // ------------------------------------------------------------
  // enables and drive selection
  // ------------------------------------------------------------
  logic [3:0] next_sincRun;
  logic       next_siggenRun;
  logic       next_highDrive;
  genvar gi;
  generate
    for (gi = 0; gi < CDC_NUM_MODULES; gi++) begin : g_sinc
      assign next_sincRun[gi] = ctrl.globalFilterEnable
                                && perModuleSincEnable[gi];
    end
  endgenerate

  always_comb begin
    next_siggenRun = ctrl.siggenEnable;
    next_highDrive = ctrl.genHighDrive;
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      sincRun       <= 4'h0;
      siggenRun     <= 1'b0;
      genHighDriveA <= 1'b0;
      genHighDriveB <= 1'b0;
    end else begin
      sincRun       <= next_sincRun;
      siggenRun     <= next_siggenRun;
      genHighDriveA <= next_highDrive;
      genHighDriveB <= next_highDrive;
    end
  end

  // ------------------------------------------------------------
  // clock dividers: tick once every field+1 cycles
  // ------------------------------------------------------------
  logic [2:0] modCnt;
  logic [2:0] next_modCnt;
  logic [3:0] sgCnt;
  logic [3:0] next_sgCnt;
  logic       next_modTick;
  logic       next_sgTick;

  always_comb begin
    next_modTick = (modCnt >= ctrl.modulatorClockDiv);
    next_modCnt  = next_modTick ? 3'h0 : modCnt + 3'h1;
    next_sgTick  = siggenRun && (sgCnt >= ctrl.siggenClockDiv);
    next_sgCnt   = (next_sgTick || !siggenRun) ? 4'h0 : sgCnt + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      modCnt     <= 3'h0;
      sgCnt      <= 4'h0;
      modClkTick <= 1'b0;
      sgClkTick  <= 1'b0;
    end else begin
      modCnt     <= next_modCnt;
      sgCnt      <= next_sgCnt;
      modClkTick <= next_modTick;
      sgClkTick  <= next_sgTick;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_startWrite;
    psel && penable && !pready && pwrite && hit && pstrb[1] && pwdata[9];
  endsequence

  sequence s_calIdle;
    calState == CAL_IDLE;
  endsequence

  property p_topZero;
    @(posedge sys_clk) disable iff (!rstSync)
      pready && !pwrite && !pslverr |-> prdata[15:13] == 3'b000;
  endproperty
  a_topZero: assert property (p_topZero)
    else $error("top bits not zero");

  property p_drive;
    @(posedge sys_clk) disable iff (!rstSync)
      ##1 genHighDriveA == $past(ctrl.genHighDrive)
          && genHighDriveB == genHighDriveA;
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive mismatch");

  property p_sinc;
    @(posedge sys_clk) disable iff (!rstSync)
      ##1 sincRun == ($past(perModuleSincEnable)
                      & {4{$past(ctrl.globalFilterEnable)}});
  endproperty
  a_sinc: assert property (p_sinc)
    else $error("sinc enable wrong");

  // a tick launched in the last enabled cycle may still stand now
  property p_sg;
    @(posedge sys_clk) disable iff (!rstSync)
      !siggenRun |=> !sgClkTick;
  endproperty
  a_sg: assert property (p_sg)
    else $error("generator ran while off");

  property p_sgIdle;
    @(posedge sys_clk) disable iff (!rstSync)
      !siggenRun |=> sgCnt == 4'h0;
  endproperty
  a_sgIdle: assert property (p_sgIdle)
    else $error("generator count not held");

  property p_start;
    @(posedge sys_clk) disable iff (!rstSync)
      s_calIdle ##0 s_startWrite |=> calStart && calState == CAL_RUN;
  endproperty
  a_start: assert property (p_start)
    else $error("calibration not started");

  property p_noRestart;
    @(posedge sys_clk) disable iff (!rstSync)
      calState == CAL_RUN |=> !calStart;
  endproperty
  a_noRestart: assert property (p_noRestart)
    else $error("calibration restarted while busy");

  property p_busyRead;
    @(posedge sys_clk) disable iff (!rstSync)
      psel && penable && !pready && !pwrite && hit
        |=> prdata[9] == $past(calState == CAL_RUN);
  endproperty
  a_busyRead: assert property (p_busyRead)
    else $error("busy bit wrong");

  property p_busyHold;
    @(posedge sys_clk) disable iff (!rstSync)
      calState == CAL_RUN && !calDone |=> calState == CAL_RUN;
  endproperty
  a_busyHold: assert property (p_busyHold)
    else $error("busy dropped early");

  property p_select;
    @(posedge sys_clk) disable iff (!rstSync)
      calStart |-> calModule == (4'b0001 << ctrl.calChannelSelect);
  endproperty
  a_select: assert property (p_select)
    else $error("wrong module");

  property p_selHold;
    @(posedge sys_clk) disable iff (!rstSync)
      calState == CAL_RUN |=> $stable(calModule);
  endproperty
  a_selHold: assert property (p_selHold)
    else $error("module changed while busy");

  // the third cycle depends on the setting seen one cycle earlier
  property p_divSg;
    @(posedge sys_clk) disable iff (!rstSync)
      sgClkTick && siggenRun && ctrl.siggenClockDiv == 4'h1
        |=> !sgClkTick ##1 (sgClkTick || !$past(siggenRun)
                            || $past(ctrl.siggenClockDiv) != 4'h1);
  endproperty
  a_divSg: assert property (p_divSg)
    else $error("generator divide wrong");

  property p_divMod;
    @(posedge sys_clk) disable iff (!rstSync)
      ctrl.modulatorClockDiv == 3'h0 |=> modClkTick;
  endproperty
  a_divMod: assert property (p_divMod)
    else $error("modulator divide wrong");

  property p_done;
    @(posedge sys_clk) disable iff (!rstSync)
      calState == CAL_RUN && calDone |=> calState == CAL_IDLE;
  endproperty
  a_done: assert property (p_done)
    else $error("busy not cleared");
endmodule

// >>> cdc_clock_divider_control_tb_top.sv
// self-checking testbench for the clock divider and generator control block
`timescale 1ns/1ps
module cdc_clock_divider_control_tb_top;
  import cdc_pkg::*;
  // ------------------------------------------------------------
  // signals and instance
  // ------------------------------------------------------------
  typedef struct {
    logic [15:0] wdata;
    logic [3:0]  per_module_sinc_enable;
    logic [15:0] rdata;
  } cdc_tb_row_t;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'h0, perModuleSincEnable = 4'h0;
  logic        calDone = 1'b0, pready, pslverr, siggenRun, calStart;
  logic        genHighDriveA, genHighDriveB, modClkTick, sgClkTick;
  logic [3:0]  sincRun, calModule;
  logic [31:0] rd;
  logic        err;
  int          badCount = 0, compares = 0, calCount = 0, n, c0;
  cdc_tb_row_t rows [6] = '{
    '{16'hfdff, 4'b1010, 16'h1dff}, '{16'h0000, 4'b1111, 16'h0000},
    '{16'h1000, 4'b0101, 16'h1000}, '{16'h0800, 4'b0110, 16'h0800},
    '{16'h0400, 4'b1111, 16'h0400}, '{16'h0185, 4'b0001, 16'h0185}};
  cdc_clock_divider_control i_cdc_clock_divider_control (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .perModuleSincEnable(perModuleSincEnable), .calDone(calDone),
    .sincRun(sincRun), .siggenRun(siggenRun), .genHighDriveA(genHighDriveA),
    .genHighDriveB(genHighDriveB), .calStart(calStart),
    .calModule(calModule), .modClkTick(modClkTick), .sgClkTick(sgClkTick));
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (calStart === 1'b1) calCount++;
  // ------------------------------------------------------------
  // helper tasks
  // ------------------------------------------------------------
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is sampled high; no fixed latency assumed
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (wr) check("wrData", 32'h0, rd);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_clk(int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // second period is used, the first may start mid-phase
  task automatic period(logic sg, output int m);
    int k;
    repeat (2) begin
      k = 0;
      while ((sg ? sgClkTick : modClkTick) !== 1'b1 && k < 40) begin
        @(posedge sys_clk);
        k++;
      end
      m = 0;
      do begin
        @(posedge sys_clk);
        m++;
      end while ((sg ? sgClkTick : modClkTick) !== 1'b1 && m < 40);
    end
  endtask
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    wait_clk(20000);
    badCount++;
    printVerdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    wait_clk(4);
    check("rstOut", 32'h0, {sincRun, siggenRun, genHighDriveA, calStart});
    reset_n <= 1'b1;
    wait_clk(3);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check("rstVal", 32'h0, rd);
    foreach (rows[i]) begin
      perModuleSincEnable <= rows[i].per_module_sinc_enable;
      apb(1'b1, 12'h000, {16'hffff, rows[i].wdata}, 4'hf);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      check("read", {16'h0, rows[i].rdata}, rd);
      wait_clk(2);
      check("high", {2{rows[i].wdata[12]}}, {genHighDriveA, genHighDriveB});
      check("sinc", rows[i].wdata[11] ? rows[i].per_module_sinc_enable : 4'h0, sincRun);
      check("sgRun", rows[i].wdata[10], siggenRun);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h000, 32'h0400 | i | ((i & 7) << 4), 4'hf);
      period(1'b1, n);
      check("sgPeriod", i + 1, n);
      period(1'b0, n);
      check("modPeriod", (i & 7) + 1, n);
    end
    for (int s = 0; s < 4; s++) begin
      c0 = calCount;
      apb(1'b1, 12'h000, 32'h0200 | (s << 7), 4'hf);
      wait_clk(3);
      check("calStart", c0 + 1, calCount);
      check("calModule", 4'b0001 << s, calModule);
      check("sgOff", 32'h0, {31'h0, sgClkTick});
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      check("busy", 32'h0200 | (s << 7), rd);
      apb(1'b1, 12'h000, 32'h0200 | (s << 7), 4'hf);
      wait_clk(3);
      check("noRestart", c0 + 1, calCount);
      calDone <= 1'b1;
      wait_clk(1);
      calDone <= 1'b0;
      wait_clk(2);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      check("idle", s << 7, rd);
    end
    apb(1'b1, 12'h000, 32'h0033, 4'hf);
    apb(1'b1, 12'h000, 32'h1cff, 4'b0010);
    apb(1'b1, 12'h004, 32'h1fff, 4'hf);
    check("wrErr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check("strobe", 32'h1c33, rd);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check("unmappedData", 32'h0, rd);
    check("unmappedErr", 32'h1, {31'h0, err});
    reset_n <= 1'b0;
    wait_clk(2);
    check("midRst", 32'h0, {sincRun, siggenRun, genHighDriveB});
    reset_n <= 1'b1;
    wait_clk(3);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check("rstAgain", 32'h0, rd);
    printVerdict();
  end
endmodule
